// ### rtl/tmode_pkg.sv
/*
  constants, field layouts and mode enumeration for the factory test-mode
  sequencer and serial trim/feature loader.
  assumes a single 10 MHz system clock domain; all pins arrive asynchronous.
*/
`default_nettype none
package tmode_pkg;
  // clock and nonvolatile commit timing
  localparam int SYS_CLK_HZ       = 10_000_000;
  localparam int NV_WRITE_TIME_US = 100;   // nonvolatile commit busy time
  localparam int NV_WRITE_CYCLES  = (NV_WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000) < 1) ? 1 :
                                    NV_WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000);
  localparam int NV_CNT_W         = 12;
  localparam logic [NV_CNT_W-1:0] NV_WRITE_CNT = NV_CNT_W'(NV_WRITE_CYCLES);

  // word widths
  localparam int CAL_W  = 17;
  localparam int FEAT_W = 18;
  localparam int SHIFT_W = 18;

  // mode-step counts from the first test mode
  localparam logic [4:0] STEP_FEATURE = 5'h02;
  localparam logic [4:0] STEP_STANDBY = 5'h04;
  localparam logic [4:0] STEP_HYST    = 5'h05;
  localparam logic [4:0] STEP_SILENCE = 5'h06;
  localparam logic [4:0] STEP_CHAMBER = 5'h07;
  localparam logic [4:0] STEP_SERIAL  = 5'h0A;
  localparam logic [4:0] STEP_MAX     = 5'h1F;

  // calibration word fields (zero-based; documented bit n is index n-1)
  localparam int STBY_LSB = 0;  localparam int STBY_W = 5;
  localparam int HYST_LSB = 5;  localparam int HYST_W = 3;
  localparam int SIL_LSB  = 8;  localparam int SIL_W  = 4;
  localparam int CHMB_LSB = 12; localparam int CHMB_W = 5;

  // feature word fields (zero-based)
  localparam int F_TONE     = 0;
  localparam int F_SIL_DISN = 1;
  localparam int F_SIL_ALRM = 2;
  localparam int F_SIL_CANC = 3;
  localparam int F_SIL_SHRT = 4;
  localparam int F_RECALL   = 5;
  localparam int F_MEMTO    = 6;   // 2 bits
  localparam int F_FLASH    = 8;
  localparam int F_CHIRP    = 9;
  localparam int F_LBSIL    = 10;
  localparam int F_SYNC     = 11;
  localparam int F_LOCDIS   = 12;
  localparam int F_GAS      = 13;
  localparam int F_EOL      = 14;
  localparam int F_LBTRIP   = 15;  // 2 bits
  localparam int F_UNIMPL   = 17;

  // sequencer modes, one-hot
  typedef enum logic [8:0] {
    MODE_NORMAL   = 9'h001,
    MODE_FIRST    = 9'h002,
    MODE_STEPPING = 9'h004,
    MODE_FEATURE  = 9'h008,
    MODE_STANDBY  = 9'h010,
    MODE_HYST     = 9'h020,
    MODE_SILENCE  = 9'h040,
    MODE_CHAMBER  = 9'h080,
    MODE_SERIAL   = 9'h100
  } mode_type;
endpackage
`default_nettype wire

// ### rtl/pin_edge_sync.sv
/*
  two-flop synchroniser with rising-edge pulse for one asynchronous pin.
  assumes pin held far longer than one sys_clk period.
*/
`default_nettype none
module pin_edge_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // pin side
  input  wire logic pin_async,
  // synchronised side
  output logic      level,
  output logic      rise
);
  typedef struct packed {
    logic meta;   // first stage, read by second only
    logic sync;   // second stage
    logic prev;   // delayed for edge detect
  } sync_type;

  sync_type st_r;
  sync_type st_nxt;

  // next-state
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = pin_async;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.sync;
  assign rise  = st_r.sync & ~st_r.prev;
endmodule // pin_edge_sync
`default_nettype wire

// ### rtl/nv_commit_timer.sv
/*
  busy timer for one nonvolatile commit: a start pulse loads the count,
  write strobe stays high until it runs out.
  assumes start only while idle; a start while busy is ignored.
*/
`default_nettype none
module nv_commit_timer
  import tmode_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // control
  input  wire logic start,
  // status
  output logic      busy
);
  typedef struct packed {
    logic [NV_CNT_W-1:0] cnt;  // cycles left
  } tmr_type;

  tmr_type st_r;
  tmr_type st_nxt;

  // count down, reload on start when idle
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - NV_CNT_W'(1);
    end else if (start) begin
      st_nxt.cnt = NV_WRITE_CNT;
    end
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = (st_r.cnt != '0);
endmodule // nv_commit_timer
`default_nettype wire

// ### rtl/test_mode_calibration_programmer.sv
/*
  factory test-mode sequencer: walks test modes on mode-step clocks,
  steps and captures sensitivity levels, shifts serial trim and feature
  words, and commits them to nonvolatile storage.
  assumes all pins are asynchronous to sys_clk; the analogue comparator
  and reference switch sit outside and are driven from here.
*/
// Overview of operation
// - level-step advances level; interconnect rise captures it
// - four mode steps reach standby calibration
// - further steps: hysteresis, silence, chamber calibration
// - test low enables comparator, switch, result out
// - no calibration commit before final interconnect pulse
// - ten steps enter serial calibration shift mode
// - interconnect pulse after 17 bits commits word
// - calibration word fields at documented bit positions
// - two steps enter feature mode, 18 bits
// - bits 17..16 pick low-battery trip, 18 unused
// - bits 15..12: end-of-life, gas, locate, sync
// - bits 11..9: battery silence, chirp, flash
// - bits 8..7 memory timeout, bit 6 recall
// - bit 5 selects short or long silence
// - bit 4 lets smoke cancel silence
// - bit 3 limits silence start to alarm
// - bit 2 high disables silence function
// - bit 1 selects continuous or temporal tone
// - comparator high when detector below reference
// - both pins low returns to normal operation
`default_nettype none
module test_mode_calibration_programmer
  import tmode_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // tester pins
  input  wire logic                mode_step_pin,
  input  wire logic                test_pin,
  input  wire logic                level_step_pin,
  input  wire logic                interconnect_pin,
  // analogue comparator side
  input  wire logic                detect_below_ref,
  output logic                     smoke_compare_enable,
  output logic                     sense_level_out,
  output logic                     test_result_out,
  output logic [4:0]               sensitivity_reference,
  // nonvolatile store
  output logic                     nv_write,
  output logic [CAL_W-1:0]         calibration_trim_word,
  output logic [FEAT_W-1:0]        user_feature_word,
  // decoded trims
  output logic [STBY_W-1:0]        standby_trim,
  output logic [HYST_W-1:0]        hysteresis_trim,
  output logic [SIL_W-1:0]         silence_trim,
  output logic [CHMB_W-1:0]        chamber_test_trim,
  // decoded features
  output logic [1:0]               low_batt_trip_sel,
  output logic                     end_of_life_on,
  output logic                     gas_alarm_link_on,
  output logic                     locate_disable,
  output logic                     sounder_sync_on,
  output logic                     low_batt_silence_on,
  output logic                     memory_chirp_on,
  output logic                     memory_flash_on,
  output logic [1:0]               memory_timeout_sel,
  output logic                     alarm_recall_on,
  output logic                     silence_short_sel,
  output logic                     silence_cancel_on,
  output logic                     silence_alarm_only,
  output logic                     silence_disable_n,
  output logic                     tone_pattern_sel,
  output logic                     silence_enabled,
  // mode status
  output logic                     normal_run_mode,
  output mode_type                 mode_state
);
  // synchronised pin views
  logic step_lvl;      // mode-step level
  logic step_rise;     // mode-step clock
  logic test_lvl;      // test pin level
  logic lstep_rise;    // level-step / shift clock
  logic ic_rise;       // interconnect rise
  logic cmp_lvl;       // comparator result
  logic nv_busy;       // commit in progress

  // all state of this module
  typedef struct packed {
    mode_type             mode;       // current test mode
    logic [4:0]           steps;      // mode-step count from first mode
    logic [4:0]           level;      // selected sensitivity level
    logic [SHIFT_W-1:0]   shreg;      // serial shift register
    logic [4:0]           nbits;      // bits shifted so far
    logic [CAL_W-1:0]     cal_stage;  // captured levels, not yet stored
    logic [3:0]           cal_done;   // one bit per captured calibration
    logic [CAL_W-1:0]     cal_word;   // stored calibration
    logic [FEAT_W-1:0]    feat_word;  // stored features
    logic                 feat_lock;  // features written this power cycle
    logic                 commit;     // start pulse to nv timer
    logic                 result;     // registered test result
    logic                 cmp_en;     // registered comparator enable
  } core_type;

  core_type st_r;
  core_type st_nxt;

  // one synchroniser per asynchronous pin
  pin_edge_sync u_sync_step (.sys_clk(sys_clk), .srst(srst), .pin_async(mode_step_pin),
                             .level(step_lvl), .rise(step_rise));
  pin_edge_sync u_sync_test (.sys_clk(sys_clk), .srst(srst), .pin_async(test_pin),
                             .level(test_lvl), .rise());
  pin_edge_sync u_sync_lstep (.sys_clk(sys_clk), .srst(srst), .pin_async(level_step_pin),
                              .level(), .rise(lstep_rise));
  pin_edge_sync u_sync_ic (.sys_clk(sys_clk), .srst(srst), .pin_async(interconnect_pin),
                           .level(), .rise(ic_rise));
  pin_edge_sync u_sync_cmp (.sys_clk(sys_clk), .srst(srst), .pin_async(detect_below_ref),
                            .level(cmp_lvl), .rise());

  // nonvolatile write strobe timer
  nv_commit_timer u_nv (.sys_clk(sys_clk), .srst(srst), .start(st_r.commit), .busy(nv_busy));

  // map a step count onto a mode
  function automatic mode_type mode_of(input logic [4:0] n);
    case (n)
      STEP_FEATURE: mode_of = MODE_FEATURE;
      STEP_STANDBY: mode_of = MODE_STANDBY;
      STEP_HYST:    mode_of = MODE_HYST;
      STEP_SILENCE: mode_of = MODE_SILENCE;
      STEP_CHAMBER: mode_of = MODE_CHAMBER;
      STEP_SERIAL:  mode_of = MODE_SERIAL;
      default:      mode_of = MODE_STEPPING;  // modes not built here
    endcase
  endfunction

  // calibration slot of the current mode
  logic       in_cal;      // any calibration mode
  logic [1:0] cal_slot;    // 0 standby .. 3 chamber
  always_comb begin
    in_cal   = 1'b1;
    cal_slot = 2'd0;
    case (st_r.mode)
      MODE_STANDBY: cal_slot = 2'd0;
      MODE_HYST:    cal_slot = 2'd1;
      MODE_SILENCE: cal_slot = 2'd2;
      MODE_CHAMBER: cal_slot = 2'd3;
      default:      in_cal   = 1'b0;
    endcase
  end

  // main next-state logic
  always_comb begin
    st_nxt        = st_r;
    st_nxt.commit = 1'b0;
    if (!step_lvl && !test_lvl) begin
      // leave every test mode; stored words survive
      st_nxt.mode  = MODE_NORMAL;
      st_nxt.steps = '0;
      st_nxt.nbits = '0;
    end else begin
      case (st_r.mode)
        MODE_NORMAL: begin
          if (step_rise) begin
            st_nxt.mode  = MODE_FIRST;
            st_nxt.steps = '0;
          end
        end
        default: begin
          // mode-step clock counts only with test held high
          if (step_rise && test_lvl && st_r.steps != STEP_MAX) begin
            st_nxt.steps = st_r.steps + 5'd1;
            st_nxt.mode  = mode_of(st_r.steps + 5'd1);
            st_nxt.level = '0;
            st_nxt.nbits = '0;
            st_nxt.shreg = '0;
          end else if (in_cal) begin
            if (lstep_rise) begin
              st_nxt.level = st_r.level + 5'd1;
            end
            if (ic_rise) begin
              // capture into staging only; storage waits for the end
              case (cal_slot)
                2'd0: st_nxt.cal_stage[STBY_LSB +: STBY_W] = st_r.level[STBY_W-1:0];
                2'd1: st_nxt.cal_stage[HYST_LSB +: HYST_W] = st_r.level[HYST_W-1:0];
                2'd2: st_nxt.cal_stage[SIL_LSB +: SIL_W]   = st_r.level[SIL_W-1:0];
                default: st_nxt.cal_stage[CHMB_LSB +: CHMB_W] = st_r.level[CHMB_W-1:0];
              endcase
              st_nxt.cal_done[cal_slot] = 1'b1;
              // a further pulse once all four are held stores them
              if (&st_r.cal_done && !nv_busy) begin
                st_nxt.cal_word = st_r.cal_stage;
                st_nxt.commit   = 1'b1;
                st_nxt.cal_done = '0;
              end
            end
          end else if (st_r.mode == MODE_SERIAL || st_r.mode == MODE_FEATURE) begin
            if (lstep_rise) begin
              // new bit enters the top, earlier bits move down, so the
              // first bit ends in bit one once the word is full
              st_nxt.shreg = {test_lvl, st_r.shreg[SHIFT_W-1:1]};
              if (st_r.nbits != STEP_MAX) begin
                st_nxt.nbits = st_r.nbits + 5'd1;
              end
            end
            if (ic_rise && !nv_busy) begin
              if (st_r.mode == MODE_SERIAL && st_r.nbits >= 5'(CAL_W)) begin
                // last 17 bits sit in the top of the register
                st_nxt.cal_word = st_r.shreg[SHIFT_W-1 -: CAL_W];
                st_nxt.commit   = 1'b1;
              end else if (st_r.mode == MODE_FEATURE && st_r.nbits >= 5'(FEAT_W)
                           && !st_r.feat_lock) begin
                // one feature write per power cycle
                st_nxt.feat_word = st_r.shreg;
                st_nxt.feat_word[F_UNIMPL] = 1'b0;
                st_nxt.feat_lock = 1'b1;
                st_nxt.commit    = 1'b1;
              end
            end
          end
        end
      endcase
    end
    // comparator path only while calibrating with test low
    st_nxt.cmp_en = in_cal && !test_lvl;
    st_nxt.result = in_cal && !test_lvl && cmp_lvl;
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r      <= '0;
      st_r.mode <= MODE_NORMAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // analogue side controls
  assign smoke_compare_enable  = st_r.cmp_en;
  assign sense_level_out       = st_r.cmp_en;  // reference switch closed
  assign test_result_out       = st_r.result;
  assign sensitivity_reference = st_r.level;

  // storage
  assign nv_write              = nv_busy;
  assign calibration_trim_word = st_r.cal_word;
  assign user_feature_word     = st_r.feat_word;

  // trim fields
  assign standby_trim      = st_r.cal_word[STBY_LSB +: STBY_W];
  assign hysteresis_trim   = st_r.cal_word[HYST_LSB +: HYST_W];
  assign silence_trim      = st_r.cal_word[SIL_LSB +: SIL_W];
  assign chamber_test_trim = st_r.cal_word[CHMB_LSB +: CHMB_W];

  // feature fields
  assign low_batt_trip_sel   = st_r.feat_word[F_LBTRIP +: 2];
  assign end_of_life_on      = st_r.feat_word[F_EOL];
  assign gas_alarm_link_on   = st_r.feat_word[F_GAS];
  assign locate_disable      = st_r.feat_word[F_LOCDIS];
  assign sounder_sync_on     = st_r.feat_word[F_SYNC];
  assign low_batt_silence_on = st_r.feat_word[F_LBSIL];
  assign memory_chirp_on     = st_r.feat_word[F_CHIRP];
  assign memory_flash_on     = st_r.feat_word[F_FLASH];
  assign memory_timeout_sel  = st_r.feat_word[F_MEMTO +: 2];
  assign alarm_recall_on     = st_r.feat_word[F_RECALL];
  assign silence_short_sel   = st_r.feat_word[F_SIL_SHRT];
  assign silence_cancel_on   = st_r.feat_word[F_SIL_CANC];
  assign silence_alarm_only  = st_r.feat_word[F_SIL_ALRM];
  assign silence_disable_n   = st_r.feat_word[F_SIL_DISN];
  assign silence_enabled     = ~st_r.feat_word[F_SIL_DISN];
  assign tone_pattern_sel    = st_r.feat_word[F_TONE];

  // mode status
  assign normal_run_mode = (st_r.mode == MODE_NORMAL);
  assign mode_state      = st_r.mode;
endmodule // test_mode_calibration_programmer
`default_nettype wire

// ### test/tmode_tester.sv
/*
  programming fixture model: drives the tester pins of the sequencer.
  assumes sys_clk comes from the bench; pins change 5 ns after its rising edge.
*/
`default_nettype none
module tmode_tester (
  // clock
  input  wire logic sys_clk,
  // tester pins
  output logic      mode_step_pin,
  output logic      test_pin,
  output logic      level_step_pin,
  output logic      interconnect_pin,
  output logic      detect_below_ref
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LINK_HALF = 4;  // half of the 800 ns link period
  localparam int IC_HOLD   = 20; // shortened commit pulse, the ms width would stall the run
  // all pins low, as at power-up
  initial begin
    {mode_step_pin, test_pin, level_step_pin, interconnect_pin, detect_below_ref} = 5'h00;
  end
  // whole cycles, landing just after an edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask
  // one mode step: low, then back high; test stays high meanwhile
  task automatic pulse_mode();
    mode_step_pin = 1'b0;
    wait_cyc(LINK_HALF);
    mode_step_pin = 1'b1;
    wait_cyc(LINK_HALF);
  endtask
  // from normal: raise step pin, raise test, then n steps
  task automatic enter(input int n);
    mode_step_pin = 1'b1;
    wait_cyc(8);
    test_pin = 1'b1;
    wait_cyc(8);
    repeat (n) pulse_mode();
  endtask
  // both pins low leaves the test modes
  task automatic leave();
    {mode_step_pin, test_pin} = 2'b00;
    wait_cyc(8);
  endtask
  // test level with settling time
  task automatic set_test(input logic v);
    test_pin = v;
    wait_cyc(8);
  endtask
  // comparator input stands in for the analogue side
  task automatic set_detect(input logic v);
    detect_below_ref = v;
    wait_cyc(8);
  endtask
  // one link clock, data held across the whole period
  task automatic shift_bit(input logic b);
    test_pin = b;
    wait_cyc(LINK_HALF);
    level_step_pin = 1'b1;
    wait_cyc(LINK_HALF);
    level_step_pin = 1'b0; // link clock stands low between bits
  endtask
  // commit strobe: high, then low
  task automatic pulse_ic();
    interconnect_pin = 1'b1;
    wait_cyc(IC_HOLD);
    interconnect_pin = 1'b0;
    wait_cyc(8);
  endtask
endmodule // tmode_tester
`default_nettype wire

// ### test/test_mode_calibration_programmer_checker.sv
/*
  concurrent checks on the sequencer ports, bound into the design.
  assumes one sys_clk domain with synchronous active-high srst.
*/
`default_nettype none
module test_mode_calibration_programmer_checker
  import tmode_pkg::*;
(
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               srst,
  // tester pins
  input wire logic               mode_step_pin,
  input wire logic               test_pin,
  input wire logic               interconnect_pin,
  // comparator side
  input wire logic               smoke_compare_enable,
  input wire logic               sense_level_out,
  input wire logic               test_result_out,
  input wire logic [4:0]         sensitivity_reference,
  // store
  input wire logic               nv_write,
  input wire logic [CAL_W-1:0]   calibration_trim_word,
  input wire logic [STBY_W-1:0]  standby_trim,
  input wire logic [HYST_W-1:0]  hysteresis_trim,
  input wire logic [SIL_W-1:0]   silence_trim,
  input wire logic [CHMB_W-1:0]  chamber_test_trim,
  // mode status
  input wire logic               normal_run_mode,
  input wire mode_type           mode_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [NV_CNT_W-1:0] nv_cnt_r; // length of the current write strobe
  // counts strobe cycles; too long for a repetition
  always_ff @(posedge sys_clk) begin
    if (srst) nv_cnt_r <= '0;
    else if (nv_write) nv_cnt_r <= nv_cnt_r + 1'b1;
    else nv_cnt_r <= '0;
  end
  // steps of a commit and of leaving the test modes
  sequence s_pins_idle;
    (!mode_step_pin && !test_pin) [*6];
  endsequence
  sequence s_ic_held;
    interconnect_pin && $past(interconnect_pin, 2);
  endsequence
  property p_idle_normal; s_pins_idle |-> normal_run_mode; endproperty
  a_idle_normal: assert property (p_idle_normal) else $error("pins idle but not normal");
  property p_level;
    $changed(sensitivity_reference) |-> sensitivity_reference == $past(sensitivity_reference) + 1'b1
      || sensitivity_reference == 5'h00;
  endproperty
  a_level: assert property (p_level) else $error("level jumped");
  property p_cmp_pair; smoke_compare_enable == sense_level_out; endproperty
  a_cmp_pair: assert property (p_cmp_pair) else $error("comparator and switch differ");
  property p_cmp_mode;
    smoke_compare_enable |-> mode_state inside {MODE_STANDBY, MODE_HYST, MODE_SILENCE, MODE_CHAMBER}
      || $past(mode_state) inside {MODE_STANDBY, MODE_HYST, MODE_SILENCE, MODE_CHAMBER};
  endproperty
  a_cmp_mode: assert property (p_cmp_mode) else $error("comparator on outside calibration");
  property p_result_gate; !smoke_compare_enable && !$past(smoke_compare_enable) |-> !test_result_out; endproperty
  a_result_gate: assert property (p_result_gate) else $error("result while comparator off");
  property p_nv_len; $fell(nv_write) |-> nv_cnt_r == NV_WRITE_CNT; endproperty
  a_nv_len: assert property (p_nv_len) else $error("write strobe length wrong");
  property p_commit; $rose(nv_write) |-> s_ic_held; endproperty
  a_commit: assert property (p_commit) else $error("write without interconnect pulse");
  property p_fields;
    $stable(calibration_trim_word) |->
      {chamber_test_trim, silence_trim, hysteresis_trim, standby_trim} == calibration_trim_word;
  endproperty
  a_fields: assert property (p_fields) else $error("trim fields misplaced");
  property p_hyst_entry; $rose(mode_state == MODE_HYST) |-> $past(mode_state) == MODE_STANDBY; endproperty
  a_hyst_entry: assert property (p_hyst_entry) else $error("bad hysteresis entry");
  property p_chmb_entry; $rose(mode_state == MODE_CHAMBER) |-> $past(mode_state) == MODE_SILENCE; endproperty
  a_chmb_entry: assert property (p_chmb_entry) else $error("bad chamber entry");
  property p_word_commit; $changed(calibration_trim_word) |=> $rose(nv_write); endproperty
  a_word_commit: assert property (p_word_commit) else $error("trim word changed without write");
endmodule // test_mode_calibration_programmer_checker
bind test_mode_calibration_programmer test_mode_calibration_programmer_checker u_chk (.*);
`default_nettype wire

// ### test/test_mode_calibration_programmer_bench.sv
/*
  self-checking bench: feature load, step calibration and serial trim load.
  assumes the fixture model drives every pin; bench owns clock and reset.
*/
`default_nettype none
module test_mode_calibration_programmer_bench
  import tmode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, srst = 1'b1;                              // clock and reset
  logic mode_step_pin, test_pin, level_step_pin, interconnect_pin, detect_below_ref;
  logic smoke_compare_enable, sense_level_out, test_result_out, nv_write, normal_run_mode;
  logic [4:0]        sensitivity_reference;
  logic [CAL_W-1:0]  calibration_trim_word;
  logic [FEAT_W-1:0] user_feature_word;
  logic [STBY_W-1:0] standby_trim;
  logic [HYST_W-1:0] hysteresis_trim;
  logic [SIL_W-1:0]  silence_trim;
  logic [CHMB_W-1:0] chamber_test_trim;
  logic [1:0]        low_batt_trip_sel, memory_timeout_sel;
  logic end_of_life_on, gas_alarm_link_on, locate_disable, sounder_sync_on, low_batt_silence_on;
  logic memory_chirp_on, memory_flash_on, alarm_recall_on, silence_short_sel, silence_cancel_on;
  logic silence_alarm_only, silence_disable_n, tone_pattern_sel, silence_enabled;
  mode_type          mode_state;
  int                error_cnt = 0;                         // mismatches
  int                tests_run = 0;                         // comparisons
  test_mode_calibration_programmer uut (.*);
  tmode_tester prog (.*);
  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // one comparison, wide enough for every port
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%0h expected=%0h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // bounded wait for the write strobe to end, so the next commit is not ignored
  task automatic wait_nv_low();
    int n = 0;
    while (nv_write !== 1'b0 && n < 1500) begin
      prog.wait_cyc(1);
      n++;
    end
    check(nv_write, 1'b0);
  endtask
  // reset held 20 cycles, then idle state
  task automatic do_reset();
    srst = 1'b1;
    prog.wait_cyc(20);
    srst = 1'b0;
    prog.wait_cyc(2);
    check({normal_run_mode, mode_state}, {1'b1, MODE_NORMAL});
    check(nv_write, 1'b0);
    check(user_feature_word, 18'h00000);
    $display("test reset done");
  endtask
  // full feature load, then every decoded output against the word
  task automatic t_feature(input logic [17:0] w);
    prog.enter(2);
    prog.wait_cyc(6);
    check(mode_state, MODE_FEATURE);
    for (int i = 0; i < FEAT_W; i++) prog.shift_bit(w[i]);
    prog.pulse_ic();
    check(nv_write, 1'b1);
    check(user_feature_word, {1'b0, w[16:0]});
    check(low_batt_trip_sel, w[16:15]);
    check({end_of_life_on, gas_alarm_link_on, locate_disable, sounder_sync_on}, w[14:11]);
    check({low_batt_silence_on, memory_chirp_on, memory_flash_on}, w[10:8]);
    check({memory_timeout_sel, alarm_recall_on}, w[7:5]);
    check(silence_short_sel, w[4]);
    check(silence_cancel_on, w[3]);
    check(silence_alarm_only, w[2]);
    check({silence_disable_n, silence_enabled}, {w[1], ~w[1]});
    check(tone_pattern_sel, w[0]);
    wait_nv_low();
    prog.leave();
    $display("test feature done");
  endtask
  // four calibration modes, level steps and captures, one final commit
  task automatic t_cal();
    logic [4:0] lv [4] = '{5'h03, 5'h05, 5'h09, 5'h11};
    mode_type   md [4] = '{MODE_STANDBY, MODE_HYST, MODE_SILENCE, MODE_CHAMBER};
    prog.enter(4);
    for (int m = 0; m < 4; m++) begin
      prog.wait_cyc(6);
      check(mode_state, md[m]);
      prog.set_test(1'b0);
      check({smoke_compare_enable, sense_level_out}, 2'b11);
      prog.set_detect(1'b1);
      check(test_result_out, 1'b1);
      prog.set_detect(1'b0);
      check(test_result_out, 1'b0);
      repeat (lv[m]) prog.shift_bit(1'b0);
      prog.wait_cyc(6);
      check(sensitivity_reference, lv[m]);
      prog.pulse_ic();
      check(nv_write, 1'b0);
      prog.set_test(1'b1);
      if (m < 3) prog.pulse_mode();
    end
    prog.pulse_ic();
    check(nv_write, 1'b1);
    check(calibration_trim_word, {5'h11, 4'h9, 3'h5, 5'h03});
    wait_nv_low();
    prog.leave();
    $display("test calibration done");
  endtask
  // serial trim load, first commit one bit short
  task automatic t_serial();
    logic [16:0] w = 17'h0B5A3;
    prog.enter(10);
    prog.wait_cyc(6);
    check(mode_state, MODE_SERIAL);
    for (int i = 0; i < 16; i++) prog.shift_bit(w[i]);
    prog.pulse_ic();
    check(nv_write, 1'b0);
    prog.shift_bit(w[16]);
    prog.pulse_ic();
    check(nv_write, 1'b1);
    check(calibration_trim_word, w);
    check({chamber_test_trim, silence_trim, hysteresis_trim, standby_trim}, w);
    wait_nv_low();
    prog.leave();
    check(normal_run_mode, 1'b1);
    $display("test serial done");
  endtask
  // watchdog well past the expected run of some 5400 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end
  // main sequence; second feature load needs a fresh start
  initial begin
    do_reset();
    t_feature(18'h37A24);
    t_cal();
    t_serial();
    do_reset();
    t_feature(18'h085DB);
    stop_test();
  end
endmodule // test_mode_calibration_programmer_bench
`default_nettype wire
